// file: tpg_regs.v
`timescale 1ns/1ps
`include "tpg_regs_map.vh"
// Function
// - Writing one to soft-reset bit 4 or 5 at FFFEH clears that channel's FIFO pointers and status; its empty flag too, unless set in that cycle.
// - A channel soft reset leaves that channel's 16-bit output buffer unchanged.
// - Only system reset clears the output buffers to zero.
// - Bank-select bit 3 at FFFFH routes the shared window to channel 0 when zero and channel 1 when one.
// - Writing the upper compare byte at FFF7H commits the entry and advances the selected FIFO unless it is full.
// - With channel 0 selected, FFF4H holds channel 0 output bits 0 to 7, bit k to output k.
// - With channel 1 selected, FFF4H holds channel 1 output bits 0 to 7, bit k to output k.
// - Output data bytes are write-only and undefined after reset.
// - FFF6H holds bits 0 to 7 of the selected channel's compare value.
// - FFF7H holds bits 8 to 15 of the selected compare value and is undefined after reset.
// - Each channel has an empty interrupt enable that suppresses or allows its empty interrupt.
// - Each channel compares its FIFO head compare value with time base bits 2 to 17 and latches the output word.
// - Each channel FIFO holds eight 32-bit entries of output word and compare value.
// - Emptying the FIFO by outputting its last entry raises the shared irq if its interrupt is enabled, never after reset, cleared by a FIFO write.
module tpg_regs (
  input wire clock,
  input wire reset,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire [17:0] time_base_counter,
  input wire ch0_empty_irq_enable,
  input wire ch1_empty_irq_enable,
  output reg [15:0] ch0_pulse_out,
  output reg [15:0] ch1_pulse_out,
  output reg channel_bank_select,
  output reg [3:0] ch0_fifo_count,
  output reg [3:0] ch1_fifo_count,
  output reg ch0_fifo_empty,
  output reg ch1_fifo_empty,
  output reg ch0_empty_flag,
  output reg ch1_empty_flag,
  output reg capture_shared_irq
);

  localparam [`TPG_CNT_W-1:0] CNT_EMPTY = 4'h0;
  localparam [`TPG_CNT_W-1:0] CNT_ONE = 4'h1;
  localparam [`TPG_CNT_W-1:0] CNT_FULL = `TPG_FIFO_DEPTH;
  localparam [`TPG_PTR_W-1:0] PTR_ONE = 3'h1;

  // address window decode, shared by both channels
  wire win_out_low;
  wire win_out_high;
  wire win_match_low;
  wire win_match_high;
  wire win_any;
  wire wr_ctrl2;
  wire wr_flag;
  wire [1:0] irq_en;
  wire [1:0] hit_vec;
  wire [1:0] flag_vec;
  wire [15:0] word0;
  wire [15:0] word1;
  wire [`TPG_CNT_W-1:0] count0;
  wire [`TPG_CNT_W-1:0] count1;
  reg bank_d;
  reg [15:0] pulse0_d;
  reg [15:0] pulse1_d;

  assign win_out_low = (addr == `TPG_ADDR_OUT_LOW);
  assign win_out_high = (addr == `TPG_ADDR_OUT_HIGH);
  assign win_match_low = (addr == `TPG_ADDR_MATCH_LOW);
  assign win_match_high = (addr == `TPG_ADDR_MATCH_HIGH);
  assign win_any = win_out_low || win_out_high || win_match_low || win_match_high;
  assign wr_ctrl2 = wr_en && (addr == `TPG_ADDR_SERVO_INPUT_CTRL2);
  assign wr_flag = wr_en && (addr == `TPG_ADDR_SERVO_FLAG_CTRL);
  assign irq_en = {ch1_empty_irq_enable, ch0_empty_irq_enable};

  always @* begin
    bank_d = channel_bank_select;
    if (wr_ctrl2) begin
      bank_d = wdata[`TPG_BIT_BANK_SELECT];
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      channel_bank_select <= `TPG_BANK_RESET;
    end else begin
      channel_bank_select <= bank_d;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      localparam [0:0] CH_ID = (ch == 1) ? 1'b1 : 1'b0;
      // staging bytes; write-only and not reset
      reg [7:0] out_low_q;
      reg [7:0] out_high_q;
      reg [7:0] match_low_q;
      reg [31:0] mem_q [0:`TPG_FIFO_DEPTH-1];
      reg [`TPG_PTR_W-1:0] wr_ptr_q;
      reg [`TPG_PTR_W-1:0] wr_ptr_d;
      reg [`TPG_PTR_W-1:0] rd_ptr_q;
      reg [`TPG_PTR_W-1:0] rd_ptr_d;
      reg [`TPG_CNT_W-1:0] count_q;
      reg [`TPG_CNT_W-1:0] count_d;
      reg flag_q;
      reg flag_d;
      wire sel;
      wire wr_sel;
      wire soft_rst;
      wire commit;
      wire [31:0] head;
      wire hit;
      wire last_out;

      assign sel = (channel_bank_select == CH_ID);
      assign wr_sel = wr_en && sel;
      assign soft_rst = wr_flag && ((ch == 0) ? wdata[`TPG_BIT_SOFT_RESET0] : wdata[`TPG_BIT_SOFT_RESET1]);
      // a full fifo drops the top compare byte
      assign commit = wr_sel && win_match_high && (count_q != CNT_FULL);
      assign head = mem_q[rd_ptr_q];
      assign hit = (count_q != CNT_EMPTY) && (head[31:16] == time_base_counter[17:2]);
      assign last_out = hit && !commit && (count_q == CNT_ONE);

      always @(posedge clock) begin
        if (wr_sel && win_out_low) begin
          out_low_q <= wdata;
        end
      end

      always @(posedge clock) begin
        if (wr_sel && win_out_high) begin
          out_high_q <= wdata;
        end
      end

      always @(posedge clock) begin
        if (wr_sel && win_match_low) begin
          match_low_q <= wdata;
        end
      end

      always @(posedge clock) begin
        if (commit) begin
          mem_q[wr_ptr_q] <= {wdata, match_low_q, out_high_q, out_low_q};
        end
      end

      always @* begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (soft_rst) begin
          wr_ptr_d = `TPG_PTR_RESET;
          rd_ptr_d = `TPG_PTR_RESET;
          count_d = `TPG_CNT_RESET;
        end else begin
          if (commit) begin
            wr_ptr_d = wr_ptr_q + PTR_ONE;
          end
          if (hit) begin
            rd_ptr_d = rd_ptr_q + PTR_ONE;
          end
          if (commit && !hit) begin
            count_d = count_q + CNT_ONE;
          end else if (hit && !commit) begin
            count_d = count_q - CNT_ONE;
          end
        end
      end

      // last entry out sets; set wins over soft reset and write clear
      always @* begin
        flag_d = flag_q;
        if (last_out) begin
          flag_d = 1'b1;
        end else if (soft_rst || (wr_sel && win_any)) begin
          flag_d = 1'b0;
        end
      end

      always @(posedge clock or posedge reset) begin
        if (reset) begin
          wr_ptr_q <= `TPG_PTR_RESET;
          rd_ptr_q <= `TPG_PTR_RESET;
          count_q <= `TPG_CNT_RESET;
          flag_q <= 1'b0;
        end else begin
          wr_ptr_q <= wr_ptr_d;
          rd_ptr_q <= rd_ptr_d;
          count_q <= count_d;
          flag_q <= flag_d;
        end
      end
    end
  endgenerate

  assign hit_vec = {g_ch[1].hit, g_ch[0].hit};
  assign word0 = g_ch[0].head[15:0];
  assign word1 = g_ch[1].head[15:0];
  assign count0 = g_ch[0].count_q;
  assign count1 = g_ch[1].count_q;
  assign flag_vec = {g_ch[1].flag_q, g_ch[0].flag_q};

  // output buffers ignore soft reset
  always @* begin
    pulse0_d = ch0_pulse_out;
    pulse1_d = ch1_pulse_out;
    if (hit_vec[0]) begin
      pulse0_d = word0;
    end
    if (hit_vec[1]) begin
      pulse1_d = word1;
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ch0_pulse_out <= `TPG_OUT_RESET;
      ch1_pulse_out <= `TPG_OUT_RESET;
    end else begin
      ch0_pulse_out <= pulse0_d;
      ch1_pulse_out <= pulse1_d;
    end
  end

  // status mirrors lag the internal state by one edge
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ch0_fifo_count <= `TPG_CNT_RESET;
      ch1_fifo_count <= `TPG_CNT_RESET;
      ch0_fifo_empty <= 1'b1;
      ch1_fifo_empty <= 1'b1;
      ch0_empty_flag <= 1'b0;
      ch1_empty_flag <= 1'b0;
      capture_shared_irq <= 1'b0;
    end else begin
      ch0_fifo_count <= count0;
      ch1_fifo_count <= count1;
      ch0_fifo_empty <= (count0 == CNT_EMPTY);
      ch1_fifo_empty <= (count1 == CNT_EMPTY);
      ch0_empty_flag <= flag_vec[0];
      ch1_empty_flag <= flag_vec[1];
      capture_shared_irq <= |(flag_vec & irq_en);
    end
  end

endmodule // tpg_regs

// file: tpg_regs_map.vh
`ifndef TPG_REGS_MAP_VH
`define TPG_REGS_MAP_VH
`define TPG_ADDR_OUT_LOW 16'hfff4
`define TPG_ADDR_OUT_HIGH 16'hfff5
`define TPG_ADDR_MATCH_LOW 16'hfff6
`define TPG_ADDR_MATCH_HIGH 16'hfff7
`define TPG_ADDR_SERVO_FLAG_CTRL 16'hfffe
`define TPG_ADDR_SERVO_INPUT_CTRL2 16'hffff
`define TPG_BIT_SOFT_RESET0 4
`define TPG_BIT_SOFT_RESET1 5
`define TPG_BIT_BANK_SELECT 3
`define TPG_FIFO_DEPTH 8
`define TPG_PTR_W 3
`define TPG_CNT_W 4
`define TPG_OUT_RESET 16'h0000
`define TPG_PTR_RESET 3'h0
`define TPG_CNT_RESET 4'h0
`define TPG_BANK_RESET 1'b0
`endif

// file: tpg_regs_sva.sv
`timescale 1ns/1ps
module tpg_regs_sva (
  input wire clock,
  input wire reset,
  input wire [15:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire ch0_empty_irq_enable,
  input wire ch1_empty_irq_enable,
  input wire [15:0] ch0_pulse_out,
  input wire channel_bank_select,
  input wire [3:0] ch0_fifo_count,
  input wire ch0_fifo_empty,
  input wire ch0_empty_flag,
  input wire ch1_empty_flag,
  input wire capture_shared_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire bw = wr_en && addr == 16'hffff;
  wire b3 = wdata[3];
  bank_sel_a: assert property (bw |=> channel_bank_select == $past(b3)) else $error("bank wrong");
  bank_hold_a: assert property (!bw |=> $stable(channel_bank_select)) else $error("bank moved");
  soft_clr_a: assert property (wr_en && addr == 16'hfffe && wdata[4] |-> ##2 ch0_fifo_count == 4'h0)
    else $error("fifo kept");
  rst_val_a: assert property ($fell(reset) |-> !ch0_pulse_out && !channel_bank_select && ch0_fifo_empty)
    else $error("bad reset value");
  head_pop_a: assert property ($changed(ch0_pulse_out) |-> ch0_fifo_count != 4'h0) else $error("pop empty");
  empty_cnt_a: assert property (ch0_fifo_empty == (ch0_fifo_count == 4'h0)) else $error("empty wrong");
  flag_set_a: assert property ($rose(ch0_empty_flag) |-> ch0_fifo_empty) else $error("flag early");
  irq_gate_a: assert property (capture_shared_irq == ($past(ch0_empty_irq_enable) && ch0_empty_flag ||
    $past(ch1_empty_irq_enable) && ch1_empty_flag)) else $error("irq wrong");
endmodule // tpg_regs_sva
bind tpg_regs tpg_regs_sva u_sva (.*);

// file: tpg_regs_tb.sv
`timescale 1ns/1ps
`define CHK(n, g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("Error %s %h %h", n, e, g); end end
module tpg_regs_tb;
  reg clock = 0, reset = 1, wr_en = 0, ch0_empty_irq_enable = 1, ch1_empty_irq_enable = 0;
  reg [7:0] wdata = 0;
  reg [15:0] addr = 0, w, c;
  reg [17:0] time_base_counter = 0;
  reg [31:0] q[$], ex, prv = 0, cur = 0;
  wire [15:0] ch0_pulse_out, ch1_pulse_out;
  wire [3:0] ch0_fifo_count, ch1_fifo_count;
  wire channel_bank_select, ch0_fifo_empty, ch1_fifo_empty, ch0_empty_flag, ch1_empty_flag, capture_shared_irq;
  integer n_fail = 0, checks_done = 0, i;
  always #2 clock = ~clock;
  tpg_regs u_dut (.*);
  task wrap_up; begin
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  task step(input integer k); begin repeat (k) @(posedge clock); #1; end endtask
  task wr(input [15:0] a, input [7:0] d); begin addr = a; wdata = d; wr_en = 1; step(1); wr_en = 0; step(1); end endtask
  task ent(input ch); begin
    wr(16'hffff, {4'h0, ch, 3'h0});
    wr(16'hfff4, w[7:0]); wr(16'hfff5, w[15:8]); wr(16'hfff6, c[7:0]); wr(16'hfff7, c[15:8]);
  end endtask
  task pop(input ch); begin
    w = $urandom; c = $urandom | 1; ent(ch);
    `CHK("count", ch ? ch1_fifo_count : ch0_fifo_count, 4'h1)
    if (ch) cur[31:16] = w; else cur[15:0] = w;
    q.push_back(cur); time_base_counter = {c, 2'h0}; step(3); time_base_counter = 0;
    `CHK("flag", ch ? ch1_empty_flag : ch0_empty_flag, 1'b1)
  end endtask
  // falling edge: outputs launched on the rising edge have settled
  always @(negedge clock) begin
    if (!reset && {ch1_pulse_out, ch0_pulse_out} !== prv) begin
      ex = q.size() ? q.pop_front() : 32'hx;
      `CHK("pulse", {ch1_pulse_out, ch0_pulse_out}, ex)
    end
    prv = {ch1_pulse_out, ch0_pulse_out};
  end
  initial begin #4000 n_fail++; wrap_up(); end
  initial begin
    void'($urandom(32'ha89db753));
    step(5); reset = 0;
    `CHK("reset", {ch1_pulse_out, ch0_pulse_out, channel_bank_select, ch0_fifo_empty, ch1_fifo_empty, ch0_empty_flag, ch1_empty_flag, capture_shared_irq}, {32'h0, 6'h18})
    $display("reset test done");
    pop(0); `CHK("irq", capture_shared_irq, 1'b1)
    pop(1); ch0_empty_irq_enable = 0; step(2); `CHK("irq", capture_shared_irq, 1'b0)
    ch1_empty_irq_enable = 1; step(2); `CHK("irq", capture_shared_irq, 1'b1)
    $display("irq test done");
    c = $urandom | 1;
    for (i = 0; i < 9; i++) begin w = $urandom; ent(0); end
    `CHK("full", {ch0_fifo_count, ch0_empty_flag}, 5'h10)
    wr(16'hfffe, 8'h30); time_base_counter = {c, 2'h0}; step(4);
    `CHK("soft", {ch0_fifo_count, ch1_empty_flag, capture_shared_irq, ch0_pulse_out}, {6'h0, cur[15:0]})
    `CHK("left", q.size(), 0)
    $display("fifo test done");
    wrap_up();
  end
endmodule // tpg_regs_tb
